// file: core/scp_top.sv
/*
 System control ports B, index/NMI mask and A on byte-wide I/O cycles.
 Assumes rd/wr are one-cycle strobes synchronous to clk_sys; pin events
 are asynchronous and synchronised here. por is a power-cycle reset.
*/
`timescale 1ns/1ps
`default_nettype none
module scp_top
    import scp_pkg::*;
(
    // Clock and resets
    input  wire logic            clk_sys,
    input  wire logic            rst,
    input  wire logic            por,
    // I/O cycle
    input  wire scp_pkg::scp_io_s io,
    output var  logic [7:0]      rdata,
    output var  logic            rvalid,
    // Pin events
    input  wire scp_pkg::scp_evt_s evt,
    // Control outputs
    output var  logic            irq0_clr,
    output var  logic            t2_gate,
    output var  logic            spk_en,
    output var  logic            nmi_mask,
    output var  logic [5:0]      cfg_ram_index,
    output var  logic            disk_light,
    output var  logic            pw_lock,
    output var  logic            gate20,
    output var  logic            cpu_reset
);
    import scp_pkg::*;

    scp_evt_s   evt_s;
    logic [3:0] b_ctrl_r;
    logic       par_latch_r;
    logic       chk_latch_r;
    logic       refresh_tgl_r;
    logic       refresh_d_r;
    logic       nmi_mask_r;
    logic [5:0] index_r;
    logic [1:0] light_r;
    logic       wdog_r;
    logic       lock_r;
    logic       gate20_r;
    logic       hot_r;
    logic       hot_trig_r;
    logic       hr_reset;
    logic       hr_busy;
    logic       wr_b;
    logic       wr_idx;
    logic       wr_a;

    assign wr_b   = io.wr && (io.addr == SCP_ADDR_B);
    assign wr_idx = io.wr && (io.addr == SCP_ADDR_INDEX);
    assign wr_a   = io.wr && (io.addr == SCP_ADDR_A);

    scp_sync #(.W($bits(scp_evt_s))) u_sync (
        .clk_sys (clk_sys),
        .rst     (rst),
        .din     (evt),
        .dout    (evt_s)
    );

    // Port B control bits
    always_ff @(posedge clk_sys)
    begin
        if (por)
            b_ctrl_r <= SCP_B_CTRL_RST;
        else if (wr_b)
            b_ctrl_r <= io.wdata[3:0]; // RULE6 RULE7 RULE8 RULE9
    end

    AST_CTRL_B: assert property ( // RULE6 RULE7
        @(posedge clk_sys) disable iff (por)
        wr_b |=> b_ctrl_r == $past(io.wdata[3:0]))
        else $error("port b control bits wrong");

    // Timer 0 latch clear pulse
    always_ff @(posedge clk_sys)
    begin
        if (rst)
            irq0_clr <= 1'b0;
        else
            irq0_clr <= wr_b && io.wdata[B_IRQ0_CLR]; // RULE1
    end

    // Error latches, event wins over nothing; enable-off clears
    always_ff @(posedge clk_sys)
    begin
        if (por)
        begin
            par_latch_r <= 1'b0;
            chk_latch_r <= 1'b0;
        end
        else
        begin
            if (b_ctrl_r[B_PAR_EN_N])
                par_latch_r <= 1'b0; // RULE21
            else if (evt_s.parity_err)
                par_latch_r <= 1'b1; // RULE2
            if (b_ctrl_r[B_CHK_EN_N])
                chk_latch_r <= 1'b0; // RULE21
            else if (evt_s.channel_err)
                chk_latch_r <= 1'b1; // RULE3
        end
    end

    AST_PAR_SET: assert property ( // RULE2
        @(posedge clk_sys) disable iff (por)
        (!b_ctrl_r[B_PAR_EN_N] && evt_s.parity_err) |=> par_latch_r)
        else $error("parity latch not set");
    AST_CHK_SET: assert property ( // RULE3
        @(posedge clk_sys) disable iff (por)
        (!b_ctrl_r[B_CHK_EN_N] && evt_s.channel_err) |=> chk_latch_r)
        else $error("channel latch not set");
    AST_CHK_OFF: assert property ( // RULE21
        @(posedge clk_sys) disable iff (por)
        b_ctrl_r[B_CHK_EN_N] |=> !chk_latch_r)
        else $error("channel latch set while disabled");

    // Refresh toggle on each rising request edge
    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            refresh_d_r   <= 1'b0;
            refresh_tgl_r <= 1'b0;
        end
        else
        begin
            refresh_d_r <= evt_s.refresh_req;
            if (evt_s.refresh_req && !refresh_d_r)
                refresh_tgl_r <= ~refresh_tgl_r; // RULE5
        end
    end

    AST_REFRESH: assert property ( // RULE5
        @(posedge clk_sys) disable iff (rst)
        (evt_s.refresh_req && !refresh_d_r) |=> $changed(refresh_tgl_r))
        else $error("refresh toggle missed");

    // Index port: NMI mask and config RAM index
    always_ff @(posedge clk_sys)
    begin
        if (por)
        begin
            nmi_mask_r <= 1'b1;
            index_r    <= SCP_IDX_RST;
        end
        else if (wr_idx)
        begin
            nmi_mask_r <= io.wdata[IDX_NMI_MASK]; // RULE10
            index_r    <= io.wdata[IDX_MSB:0]; // RULE11
        end
    end

    AST_INDEX: assert property ( // RULE11
        @(posedge clk_sys) disable iff (rst || por)
        wr_idx |=> ##1 cfg_ram_index == $past(io.wdata[IDX_MSB:0], 2))
        else $error("config index wrong");

    // Port A light bits, power-on reset only
    always_ff @(posedge clk_sys)
    begin
        if (por)
            light_r <= 2'b00;
        else if (wr_a)
            light_r <= io.wdata[A_LIGHT_A:A_LIGHT_B]; // RULE12
    end

    // Password lock: set only, cleared by power cycle
    always_ff @(posedge clk_sys)
    begin
        if (por)
            lock_r <= 1'b0;
        else if (wr_a && io.wdata[A_LOCK])
            lock_r <= 1'b1; // RULE15
    end

    // Watchdog timeout status, sticky until power-on
    always_ff @(posedge clk_sys)
    begin
        if (por)
            wdog_r <= 1'b0;
        else if (evt_s.watchdog_to)
            wdog_r <= 1'b1; // RULE14
    end

    AST_WDOG: assert property ( // RULE14
        @(posedge clk_sys) disable iff (por)
        evt_s.watchdog_to |=> wdog_r)
        else $error("watchdog status not set");

    // Gate 20 and hot reset bit
    always_ff @(posedge clk_sys)
    begin
        if (rst || por)
        begin
            gate20_r   <= 1'b0;
            hot_r      <= 1'b0;
            hot_trig_r <= 1'b0;
        end
        else
        begin
            hot_trig_r <= 1'b0;
            if (wr_a)
            begin
                gate20_r <= io.wdata[A_GATE20]; // RULE16
                hot_r    <= io.wdata[A_HOT_RST]; // RULE19
                hot_trig_r <= io.wdata[A_HOT_RST] && !hot_r; // RULE17
            end
        end
    end

    AST_HOT_TRIG: assert property ( // RULE17
        @(posedge clk_sys) disable iff (rst || por)
        (wr_a && io.wdata[A_HOT_RST] && !hot_r) |=> hot_trig_r)
        else $error("hot reset trigger missing");
    AST_GATE20: assert property ( // RULE16
        @(posedge clk_sys) disable iff (rst || por)
        wr_a |=> ##1 gate20 == $past(io.wdata[A_GATE20], 2))
        else $error("gate 20 output wrong");

    scp_hot_reset u_hot (
        .clk_sys   (clk_sys),
        .rst       (rst),
        .trig      (hot_trig_r),
        .cpu_reset (hr_reset),
        .busy      (hr_busy)
    );

    // Read data; index port is write-only, reserved bits read zero
    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            rdata  <= 8'h00;
            rvalid <= 1'b0;
        end
        else
        begin
            rvalid <= io.rd;
            rdata  <= 8'h00;
            if (io.rd && io.addr == SCP_ADDR_B)
                rdata <= {par_latch_r, chk_latch_r, evt_s.t2_out,
                          refresh_tgl_r, b_ctrl_r}; // RULE4
            else if (io.rd && io.addr == SCP_ADDR_A)
                rdata <= {light_r, 1'b0, wdog_r, lock_r, 1'b0,
                          gate20_r, hot_r}; // RULE20
        end
    end

    AST_RD_B: assert property (@(posedge clk_sys) disable iff (rst) // RULE4
        (io.rd && io.addr == SCP_ADDR_B) |=>
        rdata[B_T2_OUT] == $past(evt_s.t2_out))
        else $error("timer2 level not read back");
    AST_RD_A: assert property (@(posedge clk_sys) disable iff (rst) // RULE20
        (io.rd && io.addr == SCP_ADDR_A) |=>
        !rdata[A_WDOG+1] && !rdata[A_LOCK-1])
        else $error("reserved port a bit set");

    // Registered outputs
    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            t2_gate       <= 1'b0;
            spk_en        <= 1'b0;
            nmi_mask      <= 1'b1;
            cfg_ram_index <= 6'h00;
            disk_light    <= 1'b0;
            pw_lock       <= lock_r; // RULE15
            gate20        <= 1'b0;
            cpu_reset     <= 1'b0;
        end
        else
        begin
            t2_gate       <= b_ctrl_r[B_T2_GATE]; // RULE9
            spk_en        <= b_ctrl_r[B_SPK_EN]; // RULE8
            nmi_mask      <= nmi_mask_r; // RULE10
            cfg_ram_index <= index_r; // RULE11
            disk_light    <= |light_r; // RULE13
            pw_lock       <= lock_r; // RULE15
            gate20        <= gate20_r; // RULE16
            cpu_reset     <= hr_reset; // RULE17
        end
    end

    AST_IRQ0_CLR: assert property ( // RULE1
        @(posedge clk_sys) disable iff (rst)
        (wr_b && io.wdata[7]) |=> irq0_clr)
        else $error("timer0 clear missing");
    AST_PAR_OFF: assert property ( // RULE21
        @(posedge clk_sys) disable iff (rst || por)
        b_ctrl_r[B_PAR_EN_N] |=> !par_latch_r)
        else $error("parity latch set while disabled");
    AST_NMI: assert property ( // RULE10
        @(posedge clk_sys) disable iff (rst || por)
        wr_idx |=> ##1 nmi_mask == $past(io.wdata[7], 2))
        else $error("nmi mask wrong");
    AST_LOCK: assert property ( // RULE15
        @(posedge clk_sys) disable iff (por)
        lock_r |=> lock_r)
        else $error("lock cleared");
    AST_LIGHT: assert property ( // RULE13
        @(posedge clk_sys) disable iff (rst)
        (light_r != 2'b00) |=> disk_light)
        else $error("light off");
    AST_DELAY: assert property ( // RULE18
        @(posedge clk_sys) disable iff (rst)
        hot_trig_r |=> !hr_reset [*8])
        else $error("reset too early");
    AST_PULSE: assert property ( // RULE17
        @(posedge clk_sys) disable iff (rst)
        $rose(hr_reset) |-> hr_reset [*3] ##1 !hr_reset)
        else $error("pulse width wrong");
    AST_DONE: assert property ( // RULE18
        @(posedge clk_sys) disable iff (rst)
        hot_trig_r |-> ##[1:335] !hr_busy)
        else $error("hot reset too long");
    AST_HOT_HOLD: assert property ( // RULE19
        @(posedge clk_sys) disable iff (rst || por)
        (hot_r && !wr_a) |=> hot_r)
        else $error("hot bit dropped");
    AST_SPK_T2: assert property ( // RULE8 RULE9
        @(posedge clk_sys) disable iff (rst || por)
        wr_b |=> ##1 {spk_en, t2_gate} == $past(io.wdata[1:0], 2))
        else $error("speaker or gate output wrong");
    AST_LIGHT_OFF: assert property ( // RULE12
        @(posedge clk_sys) disable iff (rst)
        (light_r == 2'b00) |=> !disk_light)
        else $error("light on while both bits clear");
    AST_LOCK_OUT: assert property ( // RULE15
        @(posedge clk_sys) disable iff (por)
        pw_lock |=> pw_lock)
        else $error("lock output dropped");
endmodule
`default_nettype wire

// file: core/scp_pkg.sv
/*
 Constants, field positions and carrier structs for the system control ports.
 Assumes a 25 MHz system clock and byte-wide I/O cycles from the processor.
*/
// What this block does
// RULE1: Port B write bit7 clears timer0 latch
// RULE2: Port B read bit7 is parity latch
// RULE3: Port B read bit6 is channel latch
// RULE4: Port B read bit5 shows timer2 output
// RULE5: Port B bit4 toggles per refresh request
// RULE6: Port B bit3 channel enable, low active
// RULE7: Port B bit2 parity enable, low active
// RULE8: Port B bit1 speaker data enable
// RULE9: Port B bit0 drives timer2 gate
// RULE10: Index port bit7 masks NMI, write-only
// RULE11: Index bits 5-0 select config RAM byte
// RULE12: Port A bits 7,6 drive disk light
// RULE13: Status line to supply from bits 6,7
// RULE14: Port A bit4 reads watchdog timeout
// RULE15: Port A bit3 locks password, sticky
// RULE16: Port A bit1 drives address-20 gate
// RULE17: Bit0 rising write pulses reset 100-125ns
// RULE18: Reset after 6.72us, done within 13.4us
// RULE19: Bit0 stays set until write or reset
// RULE20: Reserved bits read zero, writes ignored
// RULE21: Error latches set only while enabled
package scp_pkg;
    localparam logic [15:0] SCP_ADDR_B     = 16'h0061;
    localparam logic [15:0] SCP_ADDR_INDEX = 16'h0070;
    localparam logic [15:0] SCP_ADDR_DATA  = 16'h0071;
    localparam logic [15:0] SCP_ADDR_A     = 16'h0092;
    localparam int B_IRQ0_CLR   = 7;
    localparam int B_PAR_LATCH  = 7;
    localparam int B_CHK_LATCH  = 6;
    localparam int B_T2_OUT     = 5;
    localparam int B_REFRESH    = 4;
    localparam int B_CHK_EN_N   = 3;
    localparam int B_PAR_EN_N   = 2;
    localparam int B_SPK_EN     = 1;
    localparam int B_T2_GATE    = 0;
    localparam int IDX_NMI_MASK = 7;
    localparam int IDX_MSB      = 5;
    localparam int A_LIGHT_A    = 7;
    localparam int A_LIGHT_B    = 6;
    localparam int A_WDOG       = 4;
    localparam int A_LOCK       = 3;
    localparam int A_GATE20     = 1;
    localparam int A_HOT_RST    = 0;
    localparam logic [3:0] SCP_B_CTRL_RST = 4'hc;
    localparam logic [5:0] SCP_IDX_RST    = 6'h00;
    localparam int CLK_PERIOD_PS   = 40000;
    localparam int PULSE_MIN_PS    = 100000;
    localparam int PULSE_MAX_PS    = 125000;
    localparam int DELAY_MIN_PS    = 6720000;
    localparam int DONE_MAX_PS     = 13400000;
    // Least times round up, longest round down
    localparam int PULSE_CYC = (PULSE_MIN_PS + CLK_PERIOD_PS - 1)
                               / CLK_PERIOD_PS;
    localparam int DELAY_CYC = (DELAY_MIN_PS + CLK_PERIOD_PS - 1)
                               / CLK_PERIOD_PS;
    localparam int DONE_CYC  = DONE_MAX_PS / CLK_PERIOD_PS;
    localparam int CNT_W     = 10;

    typedef struct packed {
        logic        rd;
        logic        wr;
        logic [15:0] addr;
        logic [7:0]  wdata;
    } scp_io_s;

    typedef struct packed {
        logic t2_out;
        logic refresh_req;
        logic parity_err;
        logic channel_err;
        logic watchdog_to;
    } scp_evt_s;
endpackage

// file: core/scp_sync.sv
/*
 Two-flop synchroniser for a group of pin levels.
 Assumes inputs are asynchronous to clk_sys.
*/
`timescale 1ns/1ps
`default_nettype none
module scp_sync #(
    parameter int W = 1
) (
    // Clock and reset
    input  wire logic         clk_sys,
    input  wire logic         rst,
    // Levels
    input  wire logic [W-1:0] din,
    output var  logic [W-1:0] dout
);
    logic [W-1:0] meta_r;

    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            meta_r <= '0;
            dout   <= '0;
        end
        else
        begin
            meta_r <= din;
            dout   <= meta_r;
        end
    end
endmodule
`default_nettype wire

// file: core/scp_hot_reset.sv
/*
 Alternate processor reset sequencer: waits, then pulses the reset pin.
 Assumes a one-cycle trigger on a 0 to 1 write of the hot reset bit.
*/
`timescale 1ns/1ps
`default_nettype none
module scp_hot_reset
    import scp_pkg::*;
(
    // Clock and reset
    input  wire logic clk_sys,
    input  wire logic rst,
    // Trigger and outputs
    input  wire logic trig,
    output var  logic cpu_reset,
    output var  logic busy
);
    typedef enum logic [1:0] {
        SCP_IDLE  = 2'b00,
        SCP_WAIT  = 2'b01,
        SCP_PULSE = 2'b10
    } scp_hr_e;

    scp_hr_e          state_r;
    logic [CNT_W-1:0] cnt_r;

    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            state_r   <= SCP_IDLE;
            cnt_r     <= '0;
            cpu_reset <= 1'b0;
        end
        else
        begin
            unique case (state_r)
                SCP_IDLE:
                begin
                    cpu_reset <= 1'b0;
                    if (trig)
                    begin
                        state_r <= SCP_WAIT;
                        cnt_r   <= CNT_W'(DELAY_CYC - 1);
                    end
                end
                SCP_WAIT:
                begin
                    if (cnt_r == '0)
                    begin
                        state_r   <= SCP_PULSE; // RULE18
                        cpu_reset <= 1'b1;
                        cnt_r     <= CNT_W'(PULSE_CYC - 1);
                    end
                    else
                        cnt_r <= cnt_r - 1'b1;
                end
                SCP_PULSE:
                begin
                    if (cnt_r == '0)
                    begin
                        state_r   <= SCP_IDLE; // RULE17
                        cpu_reset <= 1'b0;
                    end
                    else
                        cnt_r <= cnt_r - 1'b1;
                end
                default:
                begin
                    state_r   <= SCP_IDLE;
                    cpu_reset <= 1'b0;
                end
            endcase
        end
    end

    assign busy = (state_r != SCP_IDLE);
endmodule
`default_nettype wire

// file: bench/scp_host.sv
/*
 Host processor model issuing byte-wide I/O read and write cycles.
 Assumes the bench calls its tasks; strobes move at the falling edge.
*/
`timescale 1ns/1ps
`default_nettype none
module scp_host (
    // Clock
    input  wire logic             clk_sys,
    // I/O cycle
    output var  scp_pkg::scp_io_s io,
    input  wire logic [7:0]       rdata,
    input  wire logic             rvalid
);
    import scp_pkg::*;

    initial io = '0;

    // One write cycle to port address a, one byte per cycle
    task automatic io_wr(input logic [15:0] a, input logic [7:0] v);
        @(negedge clk_sys);
        io <= '{rd: 1'b0, wr: 1'b1, addr: a, wdata: v};
        @(negedge clk_sys);
        io.wr <= 1'b0;
        io.addr <= ~a;
        io.wdata <= ~v;
    endtask

    task automatic io_rd(input logic [15:0] a, output logic [7:0] v);
        int n;
        n = 0;
        @(negedge clk_sys);
        io.rd <= 1'b1;
        io.addr <= a;
        @(negedge clk_sys);
        io.rd <= 1'b0;
        io.addr <= ~a;
        while (rvalid !== 1'b1 && n < 4)
        begin
            @(negedge clk_sys);
            n++;
        end
        v = (rvalid === 1'b1) ? rdata : 8'hxx;
    endtask
endmodule
`default_nettype wire

// file: bench/tb_top.sv
/*
 Self-checking bench for the system control ports.
 Assumes scp_host drives the I/O cycles; pin events are driven here.
*/
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    import scp_pkg::*;
    logic       clk_sys;
    logic       rst;
    logic       por;
    scp_io_s    io;
    scp_evt_s   evt;
    logic [7:0] rdata;
    logic [5:0] cfg_ram_index;
    logic       rvalid, irq0_clr, t2_gate, spk_en, nmi_mask;
    logic       disk_light, pw_lock, gate20, cpu_reset;
    logic [7:0] w, d, aw;
    logic       tgl;
    int         k, p, n;
    int         n_errors = 0;
    int         checks_done = 0;
    integer     seed = 32'h8ade738d;

    scp_top scp_top_inst (
        .clk_sys, .rst, .por, .io, .rdata, .rvalid, .evt, .irq0_clr,
        .t2_gate, .spk_en, .nmi_mask, .cfg_ram_index, .disk_light,
        .pw_lock, .gate20, .cpu_reset
    );
    scp_host scp_host_inst (.clk_sys, .io, .rdata, .rvalid);

    initial
    begin
        clk_sys = 1'b0;
        forever #20 clk_sys = ~clk_sys;
    end

    function automatic logic [7:0] exp_b(input logic pe, ce, t, g,
                                         input logic [3:0] c);
        return {pe, ce, t, g, c};
    endfunction

    function automatic logic [7:0] exp_a(input logic [7:0] v,
                                         input logic wdg, lk);
        return {v[7:6], 1'b0, wdg, v[3] | lk, 1'b0, v[1:0]};
    endfunction

    task automatic cyc(input int c);
        repeat (c) @(negedge clk_sys);
    endtask

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        checks_done++;
        if (got !== exp)
        begin
            n_errors++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic rchk(input logic [15:0] a, input logic [7:0] e);
        logic [7:0] v;
        scp_host_inst.io_rd(a, v);
        chk(v, e);
    endtask

    task automatic wr3(input logic [15:0] a, input logic [7:0] v);
        scp_host_inst.io_wr(a, v);
        cyc(3);
    endtask

    task automatic end_of_test();
        $display("checks_done=%0d n_errors=%0d", checks_done, n_errors);
        if (n_errors == 0 && checks_done > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    initial
    begin
        evt = '0;
        rst = 1'b1;
        por = 1'b1;
        cyc(20);
        rst = 1'b0;
        por = 1'b0;
        chk({7'h00, nmi_mask}, 8'h01);
        chk({2'h0, cfg_ram_index}, 8'h00);
        scp_host_inst.io_rd(SCP_ADDR_B, d);
        chk(d & 8'hef, {4'h0, SCP_B_CTRL_RST});
        tgl = d[4];
        rchk(SCP_ADDR_A, 8'h00);
        $display("test reset done");
        for (int i = 0; i < 8; i++)
        begin
            w = (i == 0) ? 8'h80 : (i == 1) ? 8'h7f : 8'($random(seed));
            evt.t2_out = 1'($random(seed));
            scp_host_inst.io_wr(SCP_ADDR_B, w);
            k = 0;
            repeat (3)
            begin
                if (irq0_clr === 1'b1) k++;
                cyc(1);
            end
            chk(8'(k), {7'h00, w[7]});
            chk({6'h00, spk_en, t2_gate}, {6'h00, w[1:0]});
            d = exp_b(1'b0, 1'b0, evt.t2_out, tgl, w[3:0]);
            rchk(SCP_ADDR_B, d);
        end
        wr3(SCP_ADDR_B, 8'h0c);
        evt.parity_err = 1'b1;
        evt.channel_err = 1'b1;
        cyc(4);
        rchk(SCP_ADDR_B, exp_b(1'b0, 1'b0, evt.t2_out, tgl, 4'hc));
        wr3(SCP_ADDR_B, 8'h00);
        rchk(SCP_ADDR_B, exp_b(1'b1, 1'b1, evt.t2_out, tgl, 4'h0));
        evt.parity_err = 1'b0;
        evt.channel_err = 1'b0;
        cyc(4);
        rchk(SCP_ADDR_B, exp_b(1'b1, 1'b1, evt.t2_out, tgl, 4'h0));
        wr3(SCP_ADDR_B, 8'h08);
        rchk(SCP_ADDR_B, exp_b(1'b1, 1'b0, evt.t2_out, tgl, 4'h8));
        wr3(SCP_ADDR_B, 8'h0c);
        n = ($random(seed) & 3) + 1;
        repeat (n)
        begin
            evt.refresh_req = 1'b1;
            cyc(3);
            evt.refresh_req = 1'b0;
            cyc(3);
        end
        tgl = tgl ^ n[0];
        rchk(SCP_ADDR_B, exp_b(1'b0, 1'b0, evt.t2_out, tgl, 4'hc));
        $display("test port b done");
        for (int i = 0; i < 4; i++)
        begin
            w = (i == 0) ? 8'h3f : (i == 1) ? 8'hc0 : 8'($random(seed));
            wr3(SCP_ADDR_INDEX, w);
            chk({7'h00, nmi_mask}, {7'h00, w[7]});
            chk({2'h0, cfg_ram_index}, {2'h0, w[5:0]});
        end
        rchk(SCP_ADDR_INDEX, 8'h00);
        rchk(SCP_ADDR_DATA, 8'h00);
        rchk(16'h0062, 8'h00);
        $display("test index done");
        for (int i = 0; i < 4; i++)
        begin
            w = (i == 0) ? 8'h40 : (i == 1) ? 8'hb6 : 8'($random(seed));
            aw = w & 8'hf6;
            wr3(SCP_ADDR_A, aw);
            chk({6'h00, disk_light, gate20}, {6'h00, |aw[7:6], aw[1]});
            rchk(SCP_ADDR_A, exp_a(aw, 1'b0, 1'b0));
        end
        evt.watchdog_to = 1'b1;
        cyc(4);
        evt.watchdog_to = 1'b0;
        cyc(3);
        rchk(SCP_ADDR_A, exp_a(aw, 1'b1, 1'b0));
        wr3(SCP_ADDR_A, 8'h08);
        wr3(SCP_ADDR_A, 8'h00);
        chk({7'h00, pw_lock}, 8'h01);
        rchk(SCP_ADDR_A, exp_a(8'h00, 1'b1, 1'b1));
        scp_host_inst.io_wr(SCP_ADDR_A, 8'h03);
        k = 0;
        p = 0;
        while (cpu_reset !== 1'b1 && k < 400)
        begin
            cyc(1);
            k++;
        end
        while (cpu_reset === 1'b1 && p < 10)
        begin
            cyc(1);
            p++;
        end
        chk(8'(k >= DELAY_CYC), 8'h01);
        chk(8'(k + p <= DONE_CYC), 8'h01);
        chk(8'(p), 8'(PULSE_CYC));
        rchk(SCP_ADDR_A, exp_a(8'h03, 1'b1, 1'b1));
        wr3(SCP_ADDR_A, 8'h03);
        k = 0;
        repeat (250)
        begin
            if (cpu_reset === 1'b1) k++;
            cyc(1);
        end
        chk(8'(k), 8'h00);
        rst = 1'b1;
        cyc(2);
        chk({7'h00, pw_lock}, 8'h01);
        rst = 1'b0;
        cyc(2);
        chk({7'h00, gate20}, 8'h00);
        rchk(SCP_ADDR_A, exp_a(8'h00, 1'b1, 1'b1));
        $display("test port a done");
        end_of_test();
    end

    initial
    begin
        repeat (5000) @(posedge clk_sys);
        n_errors++;
        end_of_test();
    end
endmodule
`default_nettype wire
